// >>> design/bmf_pkg.sv
// Constants, field layouts, register map and carrier types of the beam framer.
// Assumes a single 50 MHz clock and a plain strobe-based register port.
// Functional notes
// - At most three units share a line; node numbers zero to two are supported.
// - First unit uses node zero; others take distinct sequential nonzero numbers.
// - Baud rates 2400, 4800, 9600, 19200, 38400, 57600, 115200 are selectable.
// - Each unit holds a configurable identifier character.
// - With change trigger on, send whenever the beam pattern differs from last scan.
// - Items: first, last, centre, count, longest run of blocked beams, bitmap.
// - A bitmap bit of one means clear, zero means blocked.
// - First beam in MSB of first bitmap byte; padding bits are zero.
// - Bitmap length is beam count divided by eight, rounded up.
// - Wide option sends each numeric measurement as two bytes.
// - Bare mode sends only the selected measurement bytes, no header or trailer.
// - Framed packet starts with one identifier byte.
// - Then one length byte equal to the payload byte count.
// - Then exactly that many payload bytes of current selected values.
// - Checksum is ones complement of the sum of all preceding packet bytes.
// - Checksum byte only when enabled; else packet ends after payload.
// - Continuous mode inserts a gap between packets; zero waits only for new data.
package bmf_pkg;

	localparam int CLK_HZ     = 50_000_000;
	localparam int MAX_NODES  = 3;
	localparam int ITEM_COUNT = 6;

	// Baud selection index to bit rate
	localparam int BAUD_RATE [7] = '{2400, 4800, 9600, 19200, 38400, 57600, 115200};
	localparam logic [2:0] BAUD_SEL_MAX = 3'h6;

	// Clock cycles per bit, rounded to nearest
	function automatic logic [15:0] bmf_divisor(input logic [2:0] sel);
		int idx;
		idx = (sel > BAUD_SEL_MAX) ? int'(BAUD_SEL_MAX) : int'(sel);
		return 16'((CLK_HZ + BAUD_RATE[idx] / 2) / BAUD_RATE[idx]);
	endfunction : bmf_divisor

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_SELECT = 8'h04;
	localparam logic [7:0] REG_FRAME  = 8'h08;
	localparam logic [7:0] REG_IDENT  = 8'h0C;
	localparam logic [7:0] REG_NODE   = 8'h10;
	localparam logic [7:0] REG_GAP    = 8'h14;
	localparam logic [7:0] REG_SLOT   = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;

	// Control register bits
	localparam int CTRL_ENABLE    = 0;
	localparam int CTRL_FRAMED    = 1;
	localparam int CTRL_CHECKSUM  = 2;
	localparam int CTRL_WIDE      = 3;
	localparam int CTRL_ON_CHANGE = 4;

	// Frame register fields
	localparam int FRAME_BAUD_LSB   = 0;
	localparam int FRAME_PARITY_LSB = 4;
	localparam int FRAME_STOP2      = 6;

	// Parity encodings
	localparam logic [1:0] PARITY_NONE = 2'h0;
	localparam logic [1:0] PARITY_EVEN = 2'h1;
	localparam logic [1:0] PARITY_ODD  = 2'h2;

	// Payload item positions, in send order
	localparam logic [2:0] ITEM_FIRST  = 3'h0;
	localparam logic [2:0] ITEM_BITMAP = 3'h5;

	// Reset values
	localparam logic [2:0]  RST_BAUD   = 3'h2;
	localparam logic [7:0]  RST_IDENT  = 8'h41;
	localparam logic [15:0] RST_SLOT   = 16'h0040;
	localparam logic [5:0]  RST_SELECT = 6'h3F;

	typedef struct packed {
		logic        enable;
		logic        framed;
		logic        checksum_en;
		logic        wide;
		logic        on_change;
		logic [2:0]  baud_sel;
		logic [1:0]  parity;
		logic        stop2;
		logic [7:0]  unit_identifier;
		logic [1:0]  node;
		logic [15:0] packet_gap_setting;
		logic [15:0] slot_bits;
		logic [5:0]  select;
	} bmf_cfg_t;

	typedef struct packed {
		logic [15:0] first_blocked_index;
		logic [15:0] last_blocked_index;
		logic [15:0] centre_blocked_index;
		logic [15:0] blocked_count;
		logic [15:0] longest_blocked_run;
	} bmf_meas_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_SLOT, ST_IDENT, ST_LEN, ST_DATA, ST_SUM, ST_GAP
	} bmf_state_t;

endpackage : bmf_pkg

// >>> design/bmf_measure.sv
// Beam scan snapshot and measurement extraction.
// Assumes scan_valid_in is a one-cycle strobe with a full beam pattern beside it.
`timescale 1ns/1ps
module bmf_measure
	import bmf_pkg::*;
#(
	parameter int NUM_BEAMS = 26
) (
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 resetn_in,
	// Scan input, one means beam clear
	input  wire logic [NUM_BEAMS-1:0] beam_clear_in,
	input  wire logic                 scan_valid_in,
	// Snapshot
	output bmf_meas_t                 meas_out,
	output logic      [NUM_BEAMS-1:0] pattern_out,
	output logic                      ready_out,
	output logic                      changed_out
);

	bmf_meas_t next_meas;

	// Beam numbers start at one so that zero can mean no blocked beam
	always_comb begin
		logic [15:0] run;
		logic [15:0] best;
		logic [15:0] cnt;
		logic [15:0] first;
		logic [15:0] last;
		logic [16:0] mid;
		run   = 16'h0000;
		best  = 16'h0000;
		cnt   = 16'h0000;
		first = 16'h0000;
		last  = 16'h0000;
		mid   = 17'h00000;
		for (int i = 0; i < NUM_BEAMS; i++) begin
			if (!beam_clear_in[i]) begin
				if (first == 16'h0000) begin
					first = 16'(i + 1);
				end
				last = 16'(i + 1);
				cnt  = cnt + 16'h0001;
				run  = run + 16'h0001;
				if (run > best) begin
					best = run;
				end
			end else begin
				run = 16'h0000;
			end
		end
		mid = ({1'b0, first} + {1'b0, last}) >> 1;
		next_meas.first_blocked_index  = first;
		next_meas.last_blocked_index   = last;
		next_meas.centre_blocked_index = mid[15:0];
		next_meas.blocked_count        = cnt;
		next_meas.longest_blocked_run  = best;
	end

	// Snapshot on every scan; change flag compares with previous pattern
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meas_out    <= '0;
			pattern_out <= '1;
			ready_out   <= 1'b0;
			changed_out <= 1'b0;
		end else begin
			ready_out <= scan_valid_in;
			if (scan_valid_in) begin
				meas_out    <= next_meas;
				pattern_out <= beam_clear_in;
				changed_out <= (beam_clear_in != pattern_out);
			end
		end
	end

endmodule : bmf_measure

// >>> design/bmf_uart_tx.sv
// Asynchronous serial byte transmitter with RS-485 driver enable.
// Assumes byte_valid_in holds until byte_ready_out accepts it.
`timescale 1ns/1ps
module bmf_uart_tx
	import bmf_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	// Framing setup
	input  wire logic [15:0] divisor_in,
	input  wire logic [1:0]  parity_in,
	input  wire logic        stop2_in,
	// Byte handshake
	input  wire logic [7:0]  byte_in,
	input  wire logic        byte_valid_in,
	output logic             byte_ready_out,
	// Line
	output logic             line_out,
	output logic             drive_en_out
);

	logic [11:0] shift;
	logic [3:0]  bits_left;
	logic [15:0] baud_cnt;
	logic        par_bit;
	logic        has_par;
	logic [3:0]  frame_bits;
	logic        take;

	assign par_bit    = (parity_in == PARITY_ODD) ? ~(^byte_in) : (^byte_in);
	assign has_par    = (parity_in == PARITY_EVEN) || (parity_in == PARITY_ODD);
	assign frame_bits = 4'h9 + {3'h0, has_par} + {3'h0, stop2_in} + 4'h1;
	assign take       = byte_valid_in && byte_ready_out;

	// Shift out start, data LSB first, parity, stops; line idles high
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			shift          <= 12'hFFF;
			bits_left      <= 4'h0;
			baud_cnt       <= 16'h0000;
			byte_ready_out <= 1'b1;
			line_out       <= 1'b1;
			drive_en_out   <= 1'b0;
		end else if (take) begin
			shift          <= has_par ? {2'h3, par_bit, byte_in, 1'b0}
			                          : {3'h7, byte_in, 1'b0};
			bits_left      <= frame_bits;
			baud_cnt       <= 16'h0000;
			byte_ready_out <= 1'b0;
			drive_en_out   <= 1'b1;
			line_out       <= 1'b1;
		end else if (bits_left != 4'h0) begin
			line_out <= shift[0];
			if (baud_cnt == divisor_in - 16'h0001) begin
				baud_cnt  <= 16'h0000;
				shift     <= {1'b1, shift[11:1]};
				bits_left <= bits_left - 4'h1;
				if (bits_left == 4'h1) begin
					byte_ready_out <= 1'b1;
				end
			end else begin
				baud_cnt <= baud_cnt + 16'h0001;
			end
		end else begin
			// Releasing the driver lets the next node take the line
			line_out     <= 1'b1;
			drive_en_out <= !byte_ready_out;
		end
	end

endmodule : bmf_uart_tx

// >>> design/bmf_framer.sv
// Beam measurement packet framer: register port, packet sequencer, serial output.
// Assumes register strobes are one cycle and scans arrive as one-cycle strobes.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module bmf_framer
	import bmf_pkg::*;
#(
	parameter int NUM_BEAMS = 26
) (
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 resetn_in,
	// Register port
	input  wire logic [7:0]           addr_in,
	input  wire logic [31:0]          wr_data_in,
	input  wire logic                 wr_en_in,
	input  wire logic                 rd_en_in,
	output logic      [31:0]          rd_data_out,
	// Beam scan
	input  wire logic [NUM_BEAMS-1:0] beam_clear_in,
	input  wire logic                 scan_valid_in,
	// RS-485 line
	output logic                      tx_line_out,
	output logic                      tx_drive_en_out,
	output logic                      busy_out
);

	localparam int BMAP_BYTES = (NUM_BEAMS + 7) / 8;
	localparam int BMAP_BITS  = BMAP_BYTES * 8;

	bmf_cfg_t   cfg;
	bmf_state_t state;
	bmf_meas_t  meas;
	bmf_meas_t  pkt_meas;

	logic [NUM_BEAMS-1:0] pattern;
	logic [NUM_BEAMS-1:0] pkt_pattern;
	logic                 meas_ready;
	logic                 meas_changed;
	logic                 pending;
	logic [2:0]           item;
	logic [7:0]           sub;
	logic [7:0]           sum;
	logic [15:0]          pkt_count;
	logic [15:0]          tick_cnt;
	logic [17:0]          wait_cnt;

	// Decode and derived wires
	logic [BMAP_BITS-1:0] bmap_flat;
	logic [15:0]          divisor;
	logic                 bit_tick;
	logic [17:0]          slot_target;
	logic [7:0]           num_bytes;
	logic [7:0]           payload_len;
	logic [15:0]          item_value;
	logic [7:0]           item_size;
	logic [7:0]           data_byte;
	logic [7:0]           bmap_byte;
	logic                 item_sel;
	logic                 item_last_byte;
	logic [7:0]           tx_byte;
	logic                 tx_valid;
	logic                 tx_ready;
	logic                 tx_take;
	logic                 trigger;
	logic                 wr_ctrl;
	logic                 wr_select;
	logic                 wr_frame;
	logic                 wr_ident;
	logic                 wr_node;
	logic                 wr_gap;
	logic                 wr_slot;
	logic [31:0]          next_rd_data;
	logic                 node_ok;

	// first beam to bitmap MSB, padding zero
	genvar g;
	generate
		for (g = 0; g < BMAP_BITS; g++) begin : g_bmap
			if (g < NUM_BEAMS) begin : g_beam
				assign bmap_flat[BMAP_BITS-1-g] = pkt_pattern[g];
			end else begin : g_pad
				assign bmap_flat[BMAP_BITS-1-g] = 1'b0;
			end
		end
	endgenerate

	// Register write decode
	assign wr_ctrl   = wr_en_in && (addr_in == REG_CTRL);
	assign wr_select = wr_en_in && (addr_in == REG_SELECT);
	assign wr_frame  = wr_en_in && (addr_in == REG_FRAME);
	assign wr_ident  = wr_en_in && (addr_in == REG_IDENT);
	assign wr_node   = wr_en_in && (addr_in == REG_NODE);
	assign wr_gap    = wr_en_in && (addr_in == REG_GAP);
	assign wr_slot   = wr_en_in && (addr_in == REG_SLOT);
	// node numbers beyond the unit limit are refused
	assign node_ok   = int'(wr_data_in[1:0]) < MAX_NODES;

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_rd_data = 32'h0000_0000;
		case (addr_in)
			REG_CTRL: begin
				next_rd_data[CTRL_ENABLE]    = cfg.enable;
				next_rd_data[CTRL_FRAMED]    = cfg.framed;
				next_rd_data[CTRL_CHECKSUM]  = cfg.checksum_en;
				next_rd_data[CTRL_WIDE]      = cfg.wide;
				next_rd_data[CTRL_ON_CHANGE] = cfg.on_change;
			end
			REG_SELECT: next_rd_data[5:0] = cfg.select;
			REG_FRAME: begin
				next_rd_data[FRAME_BAUD_LSB +: 3]   = cfg.baud_sel;
				next_rd_data[FRAME_PARITY_LSB +: 2] = cfg.parity;
				next_rd_data[FRAME_STOP2]           = cfg.stop2;
			end
			REG_IDENT:  next_rd_data[7:0]  = cfg.unit_identifier;
			REG_NODE:   next_rd_data[1:0]  = cfg.node;
			REG_GAP:    next_rd_data[15:0] = cfg.packet_gap_setting;
			REG_SLOT:   next_rd_data[15:0] = cfg.slot_bits;
			REG_STATUS: next_rd_data       = {15'h0000, busy_out, pkt_count};
			default:    next_rd_data       = 32'h0000_0000;
		endcase
	end

	// Configuration registers
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg                 <= '0;
			cfg.baud_sel        <= RST_BAUD;
			cfg.unit_identifier <= RST_IDENT;
			cfg.slot_bits       <= RST_SLOT;
			cfg.select          <= RST_SELECT;
			rd_data_out         <= 32'h0000_0000;
		end else begin
			rd_data_out <= rd_en_in ? next_rd_data : 32'h0000_0000;
			if (wr_ctrl) begin
				cfg.enable      <= wr_data_in[CTRL_ENABLE];
				cfg.framed      <= wr_data_in[CTRL_FRAMED];
				cfg.checksum_en <= wr_data_in[CTRL_CHECKSUM];
				cfg.wide        <= wr_data_in[CTRL_WIDE];
				cfg.on_change   <= wr_data_in[CTRL_ON_CHANGE];
			end
			if (wr_select) cfg.select <= wr_data_in[5:0];
			if (wr_frame) begin
				// baud index beyond the table is refused
				if (wr_data_in[FRAME_BAUD_LSB +: 3] <= BAUD_SEL_MAX) begin
					cfg.baud_sel <= wr_data_in[FRAME_BAUD_LSB +: 3];
				end
				cfg.parity <= wr_data_in[FRAME_PARITY_LSB +: 2];
				cfg.stop2  <= wr_data_in[FRAME_STOP2];
			end
			if (wr_ident) cfg.unit_identifier <= wr_data_in[7:0];
			if (wr_node && node_ok) cfg.node <= wr_data_in[1:0];
			if (wr_gap) cfg.packet_gap_setting <= wr_data_in[15:0];
			if (wr_slot) cfg.slot_bits <= wr_data_in[15:0];
		end
	end

	// Bit-time ticks pace the slot and gap waits
	assign divisor     = bmf_divisor(cfg.baud_sel);
	assign bit_tick    = (tick_cnt == divisor - 16'h0001);
	assign slot_target = 18'(cfg.node) * {2'h0, cfg.slot_bits};

	assign num_bytes = cfg.wide ? 8'h02 : 8'h01;
	assign payload_len = 8'(num_bytes * 8'({5'h00, cfg.select[0]} + {5'h00, cfg.select[1]}
	                   + {5'h00, cfg.select[2]} + {5'h00, cfg.select[3]}
	                   + {5'h00, cfg.select[4]}))
	                   + (cfg.select[ITEM_BITMAP] ? 8'(BMAP_BYTES) : 8'h00);

	// Current item value and byte
	always_comb begin
		case (item)
			3'h0:    item_value = pkt_meas.first_blocked_index;
			3'h1:    item_value = pkt_meas.last_blocked_index;
			3'h2:    item_value = pkt_meas.centre_blocked_index;
			3'h3:    item_value = pkt_meas.blocked_count;
			3'h4:    item_value = pkt_meas.longest_blocked_run;
			default: item_value = 16'h0000;
		endcase
	end

	assign item_sel       = cfg.select[item];
	assign item_size      = (item == ITEM_BITMAP) ? 8'(BMAP_BYTES) : num_bytes;
	assign item_last_byte = (sub == item_size - 8'h01);
	assign bmap_byte      = bmap_flat[(BMAP_BITS - 1 - 8 * int'(sub)) -: 8];
	assign data_byte = (item == ITEM_BITMAP) ? bmap_byte
	                 : (cfg.wide && sub == 8'h00) ? item_value[15:8] : item_value[7:0];

	// Byte source for the transmitter
	always_comb begin
		tx_valid = 1'b0;
		tx_byte  = 8'h00;
		case (state)
			ST_IDENT: begin
				tx_valid = 1'b1;
				tx_byte  = cfg.unit_identifier;
			end
			ST_LEN: begin
				tx_valid = 1'b1;
				tx_byte  = payload_len;
			end
			ST_DATA: begin
				tx_valid = item_sel;
				tx_byte  = data_byte;
			end
			ST_SUM: begin
				tx_valid = 1'b1;
				tx_byte  = ~sum;
			end
			default: begin
				tx_valid = 1'b0;
				tx_byte  = 8'h00;
			end
		endcase
	end

	assign tx_take = tx_valid && tx_ready;
	assign trigger = pending && cfg.enable && (state == ST_IDLE);

	// Packet request; a new scan wins over the start that consumes it
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pending <= 1'b0;
		end else if (meas_ready && (!cfg.on_change || meas_changed)) begin
			pending <= 1'b1;
		end else if (trigger) begin
			pending <= 1'b0;
		end
	end

	// Packet sequencer
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state       <= ST_IDLE;
			item        <= ITEM_FIRST;
			sub         <= 8'h00;
			sum         <= 8'h00;
			tick_cnt    <= 16'h0000;
			wait_cnt    <= 18'h00000;
			pkt_count   <= 16'h0000;
			pkt_meas    <= '0;
			pkt_pattern <= '1;
			busy_out    <= 1'b0;
		end else begin
			tick_cnt <= (bit_tick || state == ST_IDLE) ? 16'h0000 : tick_cnt + 16'h0001;
			busy_out <= (state != ST_IDLE);
			// modulo 256 sum of sent bytes
			if (tx_take) sum <= sum + tx_byte;
			case (state)
				ST_IDLE: begin
					if (trigger) begin
						pkt_meas    <= meas;
						pkt_pattern <= pattern;
						sum         <= 8'h00;
						wait_cnt    <= 18'h00000;
						state       <= ST_SLOT;
					end
				end
				ST_SLOT: begin
					if (wait_cnt >= slot_target) begin
						item  <= ITEM_FIRST;
						sub   <= 8'h00;
						state <= cfg.framed ? ST_IDENT : ST_DATA;
					end else if (bit_tick) begin
						wait_cnt <= wait_cnt + 18'h00001;
					end
				end
				ST_IDENT: if (tx_take) state <= ST_LEN;
				ST_LEN:   if (tx_take) state <= ST_DATA;
				ST_DATA: begin
					if (!item_sel || (tx_take && item_last_byte)) begin
						sub <= 8'h00;
						if (item == ITEM_BITMAP) begin
							state    <= (cfg.framed && cfg.checksum_en) ? ST_SUM : ST_GAP;
							wait_cnt <= 18'h00000;
						end else begin
							item <= item + 3'h1;
						end
					end else if (tx_take) begin
						sub <= sub + 8'h01;
					end
				end
				ST_SUM: begin
					if (tx_take) begin
						state    <= ST_GAP;
						wait_cnt <= 18'h00000;
					end
				end
				// Gap counts from when the last stop bit has left the line
				ST_GAP: begin
					if (tx_ready && wait_cnt >= {2'h0, cfg.packet_gap_setting}) begin
						pkt_count <= pkt_count + 16'h0001;
						state     <= ST_IDLE;
					end else if (tx_ready && bit_tick) begin
						wait_cnt <= wait_cnt + 18'h00001;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	bmf_measure #(
		.NUM_BEAMS (NUM_BEAMS)
	) u_measure (
		.clk_in        (clk_in),
		.resetn_in     (resetn_in),
		.beam_clear_in (beam_clear_in),
		.scan_valid_in (scan_valid_in),
		.meas_out      (meas),
		.pattern_out   (pattern),
		.ready_out     (meas_ready),
		.changed_out   (meas_changed)
	);

	bmf_uart_tx u_tx (
		.clk_in         (clk_in),
		.resetn_in      (resetn_in),
		.divisor_in     (divisor),
		.parity_in      (cfg.parity),
		.stop2_in       (cfg.stop2),
		.byte_in        (tx_byte),
		.byte_valid_in  (tx_valid),
		.byte_ready_out (tx_ready),
		.line_out       (tx_line_out),
		.drive_en_out   (tx_drive_en_out)
	);

endmodule : bmf_framer

// >>> tb/bmf_host_rx.sv
// Host serial receiver model standing on the far end of the line.
// Assumes the line idles high and bit time is given in clock cycles.
`timescale 1ns/1ps
module bmf_host_rx
	import bmf_pkg::*;
(
	// Clock and line
	input  wire logic        clk_in,
	input  wire logic        line_in,
	// Framing setup
	input  wire logic [15:0] bit_cycles_in,
	input  wire logic [1:0]  parity_in,
	input  wire logic        stop2_in,
	// Received byte
	output logic      [7:0]  byte_out,
	output logic             byte_valid_out,
	output logic             frame_err_out
);
	logic [7:0] b;
	logic       err;

	// Mid-bit sampling; a bad start, parity or stop raises the error flag
	initial begin
		byte_out = 8'h00;
		byte_valid_out = 1'b0;
		frame_err_out = 1'b0;
		forever begin
			@(negedge line_in);
			repeat (bit_cycles_in / 2) @(posedge clk_in);
			err = line_in;
			for (int i = 0; i < 8; i++) begin
				repeat (bit_cycles_in) @(posedge clk_in);
				b[i] = line_in;
			end
			if (parity_in == PARITY_EVEN || parity_in == PARITY_ODD) begin
				repeat (bit_cycles_in) @(posedge clk_in);
				err |= (^b ^ line_in) != (parity_in == PARITY_ODD);
			end
			for (int s = 0; s <= int'(stop2_in); s++) begin
				repeat (bit_cycles_in) @(posedge clk_in);
				err |= !line_in;
			end
			byte_out <= b;
			frame_err_out <= err;
			byte_valid_out <= 1'b1;
			@(posedge clk_in);
			byte_valid_out <= 1'b0;
		end
	end
endmodule : bmf_host_rx

// >>> tb/bmf_framer_properties.sv
// Port-level properties of the beam framer.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/1ps
module bmf_framer_properties
	import bmf_pkg::*;
#(
	parameter int NUM_BEAMS = 26
) (
	// Clock and reset
	input wire logic                 clk_in,
	input wire logic                 resetn_in,
	// Register port
	input wire logic [7:0]           addr_in,
	input wire logic [31:0]          wr_data_in,
	input wire logic                 wr_en_in,
	input wire logic                 rd_en_in,
	input wire logic [31:0]          rd_data_out,
	// Beam scan
	input wire logic [NUM_BEAMS-1:0] beam_clear_in,
	input wire logic                 scan_valid_in,
	// Line
	input wire logic                 tx_line_out,
	input wire logic                 tx_drive_en_out,
	input wire logic                 busy_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	AST_RESET_QUIET: assert property (
		$rose(resetn_in) |-> !tx_drive_en_out && tx_line_out && !busy_out && rd_data_out == 32'h0)
		else $error("outputs not quiet after reset");
	AST_IDLE_HIGH: assert property (
		!tx_drive_en_out |-> tx_line_out) else $error("line low while released");
	AST_STOP_HIGH: assert property (
		$fell(tx_drive_en_out) |-> $past(tx_line_out)) else $error("released before stop bit");
	// start bit follows drive; driver opens one cycle ahead with the line still high
	AST_START_DRIVE: assert property (
		$rose(tx_drive_en_out) |=> !tx_line_out) else $error("drive without start bit");
	AST_START_BUSY: assert property (
		$rose(tx_drive_en_out) |-> busy_out) else $error("drive outside packet");
	AST_START_LONG: assert property (
		$fell(tx_line_out) |-> !tx_line_out [*8]) else $error("low bit too short");
	AST_IDENT_RB: assert property (
		wr_en_in && addr_in == REG_IDENT ##1 rd_en_in && addr_in == REG_IDENT
		|=> rd_data_out[7:0] == $past(wr_data_in[7:0], 2)) else $error("identifier lost");
	AST_NODE_RANGE: assert property (
		rd_en_in && addr_in == REG_NODE |=> rd_data_out < 32'h3) else $error("node out of range");
	AST_BAUD_RANGE: assert property (
		rd_en_in && addr_in == REG_FRAME |=> rd_data_out[2:0] <= BAUD_SEL_MAX)
		else $error("baud index out of range");

	// Main scenarios reached
	COV_DRIVE: cover property ($rose(tx_drive_en_out));
	COV_DONE: cover property ($fell(busy_out));
	COV_CTRL: cover property (wr_en_in && addr_in == REG_CTRL);
endmodule : bmf_framer_properties

bind bmf_framer bmf_framer_properties #(.NUM_BEAMS(NUM_BEAMS)) i_bmf_framer_properties (
	.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
	.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
	.beam_clear_in(beam_clear_in), .scan_valid_in(scan_valid_in), .tx_line_out(tx_line_out),
	.tx_drive_en_out(tx_drive_en_out), .busy_out(busy_out));

// >>> tb/bmf_framer_tb_top.sv
// Self-checking bench: registers, packet formats, change trigger.
// Assumes the host receiver model and the bound checker.
`timescale 1ns/1ps
module bmf_framer_tb_top;
	import bmf_pkg::*;
	localparam int NB = 12;
	localparam logic [15:0] BITC = 16'h01B2;
	logic clk_in, resetn_in, wr_en_in, rd_en_in, scan_valid_in, rd_d, stop2;
	logic tx_line_out, tx_drive_en_out, busy_out, rx_valid, rx_err;
	logic [7:0]    addr_in, rx_byte, idn;
	logic [31:0]   wr_data_in, rd_data_out;
	logic [NB-1:0] beam_clear_in, p;
	logic [1:0]    par;
	logic [8:0]    bq[$];
	logic [31:0]   rq[$];
	int            fails, samples_checked, cyc;
	// Failsafe bias holds a released line high
	wire logic     line = tx_drive_en_out ? tx_line_out : 1'b1;

	bmf_framer #(.NUM_BEAMS(NB)) i_bmf_framer (.clk_in(clk_in), .resetn_in(resetn_in),
		.addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
		.rd_data_out(rd_data_out), .beam_clear_in(beam_clear_in), .scan_valid_in(scan_valid_in),
		.tx_line_out(tx_line_out), .tx_drive_en_out(tx_drive_en_out), .busy_out(busy_out));
	bmf_host_rx i_bmf_host_rx (.clk_in(clk_in), .line_in(line), .bit_cycles_in(BITC),
		.parity_in(par), .stop2_in(stop2), .byte_out(rx_byte), .byte_valid_out(rx_valid),
		.frame_err_out(rx_err));

	task automatic wrap_up;
		if (fails == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Strobes stay up between back-to-back accesses; idle drops them
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		rd_en_in <= 1'b0;
		@(posedge clk_in);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		addr_in <= a;
		wr_en_in <= 1'b0;
		rd_en_in <= 1'b1;
		@(posedge clk_in);
	endtask : rd

	task automatic idle;
		wr_en_in <= 1'b0;
		rd_en_in <= 1'b0;
		@(posedge clk_in);
	endtask : idle

	// Items by index: first, last, centre, count, longest run
	function automatic logic [15:0] item(input logic [NB-1:0] q, input int k);
		int f, l, n, r, run;
		f = 0;
		l = 0;
		n = 0;
		r = 0;
		run = 0;
		for (int i = 0; i < NB; i++) begin
			run = q[i] ? 0 : run + 1;
			r = (run > r) ? run : r;
			n += int'(!q[i]);
			l = q[i] ? l : i + 1;
			f = (q[i] || f != 0) ? f : i + 1;
		end
		case (k)
			0: return 16'(f);
			1: return 16'(l);
			2: return 16'((f + l) / 2);
			3: return 16'(n);
			default: return 16'(r);
		endcase
	endfunction : item

	// Notes the expected bytes, configures, then fires one scan
	task automatic pkt(input logic [4:0] c, input logic [5:0] sel, input logic [6:0] frm,
		input logic [NB-1:0] q, input logic send);
		logic [7:0]  b[$];
		logic [7:0]  s;
		logic [15:0] v;
		for (int k = 0; k < 5; k++) begin
			v = item(q, k);
			if (sel[k] && c[CTRL_WIDE]) b.push_back(v[15:8]);
			if (sel[k]) b.push_back(v[7:0]);
		end
		for (int i = 0; i < NB && sel[5]; i += 8) begin
			v = 16'h0000;
			for (int m = 0; m < 8; m++) v[7-m] = (i + m < NB) ? q[i+m] : 1'b0;
			b.push_back(v[7:0]);
		end
		s = idn + 8'(b.size());
		if (send && c[CTRL_FRAMED]) bq.push_back({1'b0, idn});
		if (send && c[CTRL_FRAMED]) bq.push_back({1'b0, 8'(b.size())});
		foreach (b[j]) begin
			s += b[j];
			if (send) bq.push_back({1'b0, b[j]});
		end
		if (send && c[CTRL_FRAMED] && c[CTRL_CHECKSUM]) bq.push_back({1'b0, ~s});
		par <= frm[5:4];
		stop2 <= frm[6];
		wr(REG_FRAME, {25'h0, frm});
		wr(REG_SELECT, {26'h0, sel});
		wr(REG_CTRL, {27'h0, c});
		beam_clear_in <= q;
		scan_valid_in <= 1'b1;
		idle();
		scan_valid_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		if (!send) chk({31'h0, busy_out}, 32'h0, "busy_out");
		while (bq.size() > 0 || busy_out) @(posedge clk_in);
	endtask : pkt

	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	// Oldest note checked as each read word or line byte appears
	always @(posedge clk_in) begin
		cyc++;
		if (rd_d) chk(rd_data_out, rq.pop_front(), "rd_data_out");
		if (rx_valid) chk({23'h0, rx_err, rx_byte}, {23'h0, bq.size() ? bq.pop_front() : 9'h1FF}, "rx_byte");
		rd_d <= rd_en_in;
		if (cyc == 100000) begin
			fails++;
			wrap_up();
		end
	end

	initial begin
		{resetn_in, wr_en_in, rd_en_in, scan_valid_in, stop2} = 5'h00;
		addr_in = 8'h00;
		wr_data_in = 32'h0;
		beam_clear_in = '1;
		par = PARITY_NONE;
		fails = 0;
		samples_checked = 0;
		cyc = 0;
		void'($urandom(24));
		idn = 8'($urandom);
		repeat (16) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		// reset values, refused fields, unmapped place
		rd(REG_CTRL, 32'h0);
		rd(REG_SELECT, 32'h3F);
		rd(REG_IDENT, 32'h41);
		rd(REG_SLOT, 32'h40);
		rd(REG_GAP, 32'h0);
		rd(8'h20, 32'h0);
		wr(REG_NODE, 32'h3);
		rd(REG_NODE, 32'h0);
		wr(REG_NODE, 32'h2);
		rd(REG_NODE, 32'h2);
		wr(REG_NODE, 32'h0);
		wr(REG_FRAME, 32'h17);
		rd(REG_FRAME, 32'h12);
		wr(REG_IDENT, {24'h0, idn});
		rd(REG_IDENT, {24'h0, idn});
		idle();
		p = NB'($urandom);
		pkt(5'h07, 6'h08, 7'h16, p, 1'b1);
		pkt(5'h01, 6'h3F, 7'h66, ~p, 1'b1);
		pkt(5'h0B, 6'h08, 7'h06, p, 1'b1);
		pkt(5'h11, 6'h08, 7'h06, p, 1'b0);
		pkt(5'h11, 6'h08, 7'h06, ~p, 1'b1);
		wrap_up();
	end
endmodule : bmf_framer_tb_top
